// ### hw/jtp_tap.sv
// test access port controller with instruction and data chains
`timescale 1ns/1ps

module jtp_tap
    import jtp_pkg::*;
(
    // system clock and power-on reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // probe pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_n_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // pin function select, high for test function
    output logic pin_test_sel_o,
    // boundary values applied to the pins
    output logic [7:0] bnd_out_o,
    // boundary values sampled from the pins
    input wire logic [7:0] bnd_in_i,
    // user words toward the core
    output logic usr_valid_o,
    output logic [7:0] usr_data_o,
    input wire logic usr_ready_i,
    // current controller state
    output logic [3:0] tap_state_o
);

    // synchronisers for the pins
    logic [1:0] tck_s_q;
    logic [1:0] tms_s_q;
    logic [1:0] tdi_s_q;
    logic [1:0] trst_s_q;
    logic tck_d1_q; // previous synced clock
    logic tck_rise;
    logic tck_fall;
    logic trst_n;

    // controller state and chains
    jtp_state_t state_q;
    jtp_state_t state_d;
    logic [IR_LEN-1:0] ir_sh_q; // instruction shift stage
    logic [IR_LEN-1:0] ir_q; // instruction parallel stage
    logic byp_q; // bypass bit
    logic [ID_LEN-1:0] id_sh_q; // identification chain
    logic [BND_LEN-1:0] bnd_sh_q; // boundary shift stage
    logic [BND_LEN-1:0] bnd_q; // boundary parallel stage
    logic [USR_LEN-1:0] usr_sh_q; // user shift stage
    jtp_sel_t sel;

    // two-entry buffer for user words
    logic [USR_LEN-1:0] buf_mem_q [BUF_DEPTH];
    logic buf_wr_q;
    logic buf_rd_q;
    logic [1:0] buf_cnt_q;
    logic usr_push;
    logic usr_ready_in;

    // two flip-flops on each asynchronous pin
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            // idle level of the pulled-up clock pin, so no false edge follows reset
            tck_s_q <= 2'h3;
            tms_s_q <= 2'h3;
            tdi_s_q <= 2'h3;
            trst_s_q <= 2'h0;
        end
        else
        begin
            tck_s_q <= {tck_s_q[0], tck_i};
            tms_s_q <= {tms_s_q[0], tms_i};
            tdi_s_q <= {tdi_s_q[0], tdi_i};
            trst_s_q <= {trst_s_q[0], trst_n_i};
        end
    end

    // edge finder on the synced test clock
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            tck_d1_q <= 1'b1; // matches the synced idle high level
        else
            tck_d1_q <= tck_s_q[1];
    end

    // with test reset high, no edge means the controller and chains do not move, so a stopped clock holds them
    assign tck_rise = tck_s_q[1] & ~tck_d1_q;
    assign tck_fall = ~tck_s_q[1] & tck_d1_q;
    // raw pin also gates, so assertion acts at once
    assign trst_n = trst_s_q[1] & trst_n_i;

    // instruction decode; unknown codes fall back to bypass
    function automatic jtp_sel_t decode(input logic [IR_LEN-1:0] insn);
        unique case (insn)
            INSN_IDCODE: decode = SEL_IDCODE;
            INSN_SAMPLE: decode = SEL_BOUNDARY;
            INSN_USER: decode = SEL_USER;
            INSN_EXTEST, INSN_INTEST: decode = SEL_HOLD;
            default: decode = SEL_BYPASS;
        endcase
    endfunction

    // held instruction selects the data chain
    assign sel = decode(ir_q);

    // next state from current state and mode
    always_comb
    begin
        unique case (state_q)
            TEST_LOGIC_RESET: state_d = tms_s_q[1] ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
            RUN_TEST_IDLE: state_d = tms_s_q[1] ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR: state_d = tms_s_q[1] ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR: state_d = tms_s_q[1] ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: state_d = tms_s_q[1] ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: state_d = tms_s_q[1] ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR: state_d = tms_s_q[1] ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: state_d = tms_s_q[1] ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR: state_d = tms_s_q[1] ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR: state_d = tms_s_q[1] ? TEST_LOGIC_RESET : CAPTURE_IR;
            CAPTURE_IR: state_d = tms_s_q[1] ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: state_d = tms_s_q[1] ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: state_d = tms_s_q[1] ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR: state_d = tms_s_q[1] ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: state_d = tms_s_q[1] ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR: state_d = tms_s_q[1] ? SELECT_DR : RUN_TEST_IDLE;
        endcase
    end

    // controller state register on rising test clock
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            state_q <= TEST_LOGIC_RESET;
        else if (!trst_n)
            state_q <= TEST_LOGIC_RESET;
        else if (tck_rise)
            state_q <= state_d;
    end

    // instruction chain: capture, shift, update
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ir_sh_q <= INSN_IDCODE;
            ir_q <= INSN_IDCODE;
        end
        else if (!trst_n || state_q == TEST_LOGIC_RESET)
        begin
            ir_sh_q <= INSN_IDCODE;
            ir_q <= INSN_IDCODE;
        end
        else if (tck_rise)
        begin
            unique case (state_q)
                CAPTURE_IR: ir_sh_q <= IR_CAPTURE;
                SHIFT_IR: ir_sh_q <= {tdi_s_q[1], ir_sh_q[IR_LEN-1:1]};
                default: ;
            endcase
        end
        else if (tck_fall && state_q == UPDATE_IR)
            ir_q <= ir_sh_q;
    end

    // data chains, each acting only while selected
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            byp_q <= 1'b0;
            id_sh_q <= ID_VALUE;
            bnd_sh_q <= 8'h00;
            usr_sh_q <= 8'h00;
        end
        else if (tck_rise && state_q == CAPTURE_DR)
        begin
            unique case (sel)
                SEL_BYPASS: byp_q <= 1'b0;
                SEL_IDCODE: id_sh_q <= ID_VALUE;
                SEL_BOUNDARY: bnd_sh_q <= bnd_in_i;
                SEL_USER: usr_sh_q <= 8'h00;
                SEL_HOLD: ;
            endcase
        end
        else if (tck_rise && state_q == SHIFT_DR)
        begin
            unique case (sel)
                SEL_BYPASS: byp_q <= tdi_s_q[1];
                SEL_IDCODE: id_sh_q <= {tdi_s_q[1], id_sh_q[ID_LEN-1:1]};
                SEL_BOUNDARY: bnd_sh_q <= {tdi_s_q[1], bnd_sh_q[BND_LEN-1:1]};
                SEL_USER: usr_sh_q <= {tdi_s_q[1], usr_sh_q[USR_LEN-1:1]};
                SEL_HOLD: ;
            endcase
        end
    end

    // boundary parallel stage updated on falling edge in update state
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
            bnd_q <= 8'h00;
        else if (tck_fall && state_q == UPDATE_DR && sel == SEL_BOUNDARY)
            bnd_q <= bnd_sh_q;
    end

    // user update pushes a word; dropped only if buffer full
    assign usr_push = tck_fall && state_q == UPDATE_DR && sel == SEL_USER && usr_ready_in;
    assign usr_ready_in = buf_cnt_q != 2'h2;

    // two-entry buffer toward the core
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            buf_wr_q <= 1'b0;
            buf_rd_q <= 1'b0;
            buf_cnt_q <= 2'h0;
            buf_mem_q[0] <= 8'h00;
            buf_mem_q[1] <= 8'h00;
        end
        else
        begin
            if (usr_push)
            begin
                buf_mem_q[buf_wr_q] <= usr_sh_q;
                buf_wr_q <= ~buf_wr_q;
            end
            if (usr_valid_o && usr_ready_i)
                buf_rd_q <= ~buf_rd_q;
            buf_cnt_q <= buf_cnt_q + {1'b0, usr_push} - {1'b0, usr_valid_o && usr_ready_i};
        end
    end

    // registered core side of the buffer
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            usr_valid_o <= 1'b0;
            usr_data_o <= 8'h00;
        end
        else
        begin
            usr_valid_o <= (buf_cnt_q - {1'b0, usr_valid_o && usr_ready_i}) != 2'h0;
            usr_data_o <= buf_mem_q[(usr_valid_o && usr_ready_i) ? ~buf_rd_q : buf_rd_q];
        end
    end

    // data out and its enable change on falling edge
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (!trst_n)
        begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe_o <= state_q == SHIFT_IR || state_q == SHIFT_DR;
            if (state_q == SHIFT_IR)
                tdo_o <= ir_sh_q[0];
            else
            begin
                unique case (sel)
                    SEL_IDCODE: tdo_o <= id_sh_q[0];
                    SEL_BOUNDARY: tdo_o <= bnd_sh_q[0];
                    SEL_USER: tdo_o <= usr_sh_q[0];
                    default: tdo_o <= byp_q;
                endcase
            end
        end
    end

    // pin function and status outputs
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_test_sel_o <= 1'b1;
            bnd_out_o <= 8'h00;
            tap_state_o <= 4'h0;
        end
        else
        begin
            pin_test_sel_o <= 1'b1;
            bnd_out_o <= bnd_q;
            tap_state_o <= state_q;
        end
    end

    // assertions
    AST_TRST_HOLD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !trst_n |=> state_q == TEST_LOGIC_RESET)
        else $error("test reset did not force reset state");

    AST_IR_DEFAULT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state_q == TEST_LOGIC_RESET |=> ir_q == INSN_IDCODE)
        else $error("instruction not identification in reset state");

    AST_STATIC_CLOCK: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !tck_rise && trst_n && !$past(reset_i) |=> $stable(state_q))
        else $error("state changed without clock edge");

    AST_OE_SHIFT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        tdo_oe_o |-> $past(state_q) == SHIFT_IR || $past(state_q) == SHIFT_DR
            || $past(tdo_oe_o))
        else $error("data out enabled outside shift");

    AST_TDO_FALL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $changed(tdo_o) |-> $past(tck_fall) || !$past(trst_n))
        else $error("data out changed off falling edge");

    AST_HOLD_CHAINS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sel == SEL_HOLD && state_q == SHIFT_DR |=> $stable(bnd_sh_q) && $stable(usr_sh_q))
        else $error("chain moved under extest or intest");

    AST_BYPASS: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        tck_rise && state_q == SHIFT_DR && sel == SEL_BYPASS |=> byp_q == $past(tdi_s_q[1]))
        else $error("bypass bit did not take data in");

    AST_RESET_STATE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        tck_rise && trst_n && tms_s_q[1] && state_q == SELECT_IR |=> state_q == TEST_LOGIC_RESET)
        else $error("mode high did not walk to reset state");

endmodule // jtp_tap

// ### hw/jtp_pkg.sv
// package for the test access port block: states, instruction codes, chain sizes
package jtp_pkg;

    // sixteen standard controller states
    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } jtp_state_t;

    // instruction chain length
    localparam int IR_LEN = 4;
    // identification chain length
    localparam int ID_LEN = 32;
    // boundary chain length
    localparam int BND_LEN = 8;
    // user data chain length
    localparam int USR_LEN = 8;

    // implemented instruction codes
    localparam logic [3:0] INSN_EXTEST = 4'h0;
    localparam logic [3:0] INSN_INTEST = 4'h1;
    localparam logic [3:0] INSN_SAMPLE = 4'h2;
    localparam logic [3:0] INSN_USER = 4'h8;
    localparam logic [3:0] INSN_IDCODE = 4'he;
    localparam logic [3:0] INSN_BYPASS = 4'hf;

    // fixed pattern captured into the instruction chain
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // identification value; arbitrary
    localparam logic [31:0] ID_VALUE = 32'h1000_0001;

    // chains selectable between data in and data out
    typedef enum logic [2:0] {
        SEL_BYPASS, SEL_IDCODE, SEL_BOUNDARY, SEL_USER, SEL_HOLD
    } jtp_sel_t;

    // buffer depth between the chain update and the core side
    localparam int BUF_DEPTH = 2;

endpackage

// ### testbench/jtp_probe.sv
// behavioural test probe that drives the tap pins from the system clock
`timescale 1ns/1ps
module jtp_probe (
    // pacing clock
    input wire logic sys_clk_i,
    // data out from the device
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    // probe pins
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    logic tdo_wire; // pin level, pulled up when released
    assign tdo_wire = tdo_oe_i ? tdo_i : 1'b1;
    // pins idle high as the pull-ups leave them
    initial
    begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // one test clock of 400 ns: fall with new pins, read the pin, then rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge sys_clk_i);
        tck_o <= 1'b0;
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (4) @(posedge sys_clk_i);
        // data out was set after the fall, read it as the clock rises
        tdo = tdo_wire;
        tck_o <= 1'b1;
        // three edges here and the next call's first edge give four cycles high, eight in all
        repeat (3) @(posedge sys_clk_i);
    endtask
    // idle to shift, n bits lsb first, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir)
        begin
            step(1'b1, 1'b1, b);
        end
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // jtp_probe

// ### testbench/testbench.sv
// self-checking bench for the test access port block
`timescale 1ns/1ps
module testbench;
    import jtp_pkg::*;
    logic sys_clk_i, reset_i, trst_n_i, tck, tms, tdi, tdo, tdo_oe, pin_sel, usr_valid, usr_ready_i, b;
    logic [7:0] bnd_out, bnd_in_i, usr_data;
    logic [3:0] state;
    logic [31:0] d;
    int error_cnt = 0;
    int comparisons = 0;
    jtp_tap DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pin_test_sel_o(pin_sel), .bnd_out_o(bnd_out),
        .bnd_in_i(bnd_in_i), .usr_valid_o(usr_valid), .usr_data_o(usr_data), .usr_ready_i(usr_ready_i),
        .tap_state_o(state));
    jtp_probe u_probe (.sys_clk_i(sys_clk_i), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi));
    // 20 MHz system clock
    initial
    begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // compare and count
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (exp !== got)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            error_cnt++;
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // identification chain read back through the current instruction
    task automatic read_id();
        u_probe.scan(1'b0, 32, 32'h0, d);
        chk("idcode", ID_VALUE, d);
    endtask
    // defaults after power-on reset
    task automatic t_reset();
        chk("state", TEST_LOGIC_RESET, state);
        chk("pin_sel", 1'b1, pin_sel);
        chk("oe_idle", 1'b0, tdo_oe);
        u_probe.step(1'b0, 1'b1, b);
        read_id();
        chk("oe_after", 1'b0, tdo_oe);
    endtask
    // ir length, capture value and bypass decode of unknown codes
    task automatic t_bypass();
        logic [3:0] codes [2] = '{4'h3, 4'hf};
        u_probe.scan(1'b1, 8, 32'hf3, d);
        chk("ir_len", 32'h31, d);
        foreach (codes[i])
        begin
            u_probe.scan(1'b1, 4, {28'h0, codes[i]}, d);
            u_probe.scan(1'b0, 4, 32'hb, d);
            chk("bypass", 32'h6, d);
        end
        repeat (100) @(posedge sys_clk_i);
        chk("static_state", RUN_TEST_IDLE, state);
    endtask
    // sample and preload, then extest and intest leave the chain alone
    task automatic t_boundary();
        logic [3:0] codes [2] = '{INSN_EXTEST, INSN_INTEST};
        bnd_in_i <= 8'h3c;
        u_probe.scan(1'b1, 4, {28'h0, INSN_SAMPLE}, d);
        u_probe.scan(1'b0, 8, 32'h96, d);
        chk("bnd_capture", 32'h3c, d);
        chk("bnd_update", 8'h96, bnd_out);
        foreach (codes[i])
        begin
            bnd_in_i <= 8'hc3;
            u_probe.scan(1'b1, 4, {28'h0, codes[i]}, d);
            u_probe.scan(1'b0, 8, 32'h5a, d);
            chk("bnd_frozen", 8'h96, bnd_out);
        end
    endtask
    // user words fill the buffer while the core stalls, then drain
    task automatic t_user();
        int n;
        usr_ready_i <= 1'b0;
        u_probe.scan(1'b1, 4, {28'h0, INSN_USER}, d);
        for (int i = 1; i <= 3; i++)
            u_probe.scan(1'b0, 8, 32'ha0 + i, d);
        n = 0;
        while (usr_valid !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        chk("usr_valid", 1'b1, usr_valid);
        chk("usr_word1", 8'ha1, usr_data);
        for (int i = 2; i <= 3; i++)
        begin
            @(posedge sys_clk_i);
            usr_ready_i <= 1'b1;
            @(posedge sys_clk_i);
            usr_ready_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
            if (i == 2)
                chk("usr_word2", 8'ha2, usr_data);
            else
                chk("usr_empty", 1'b0, usr_valid);
        end
    endtask
    // five mode-high clocks from shift reach reset and restore idcode
    task automatic t_five();
        u_probe.step(1'b1, 1'b1, b);
        u_probe.step(1'b0, 1'b1, b);
        u_probe.step(1'b0, 1'b1, b);
        repeat (5) u_probe.step(1'b1, 1'b1, b);
        // state output lags the last rising edge by four system clocks
        repeat (2) @(posedge sys_clk_i);
        chk("five_state", TEST_LOGIC_RESET, state);
        u_probe.step(1'b0, 1'b1, b);
        read_id();
    endtask
    // test reset in mid-shift forces and holds reset state
    task automatic t_trst();
        u_probe.scan(1'b1, 4, {28'h0, INSN_BYPASS}, d);
        u_probe.step(1'b1, 1'b1, b);
        u_probe.step(1'b0, 1'b1, b);
        u_probe.step(1'b0, 1'b1, b);
        // one falling edge inside shift so the output is driven first
        u_probe.step(1'b0, 1'b1, b);
        chk("trst_oe_on", 1'b1, tdo_oe);
        trst_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk("trst_state", TEST_LOGIC_RESET, state);
        chk("trst_oe", 1'b0, tdo_oe);
        repeat (2) u_probe.step(1'b0, 1'b1, b);
        chk("trst_hold", TEST_LOGIC_RESET, state);
        trst_n_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        u_probe.step(1'b0, 1'b1, b);
        read_id();
    endtask
    // main sequence
    initial
    begin
        reset_i = 1'b1;
        trst_n_i = 1'b1;
        bnd_in_i = 8'h00;
        usr_ready_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        t_reset();
        t_bypass();
        t_boundary();
        t_user();
        t_five();
        t_trst();
        summarize();
    end
    // cut a hang short
    initial
    begin
        repeat (90000) @(posedge sys_clk_i);
        error_cnt++;
        summarize();
    end
endmodule // testbench
